// ==== logic/monitor_interrupt_status.sv ====
// Interrupt status registers of the hardware monitor, with configuration
// register one and the fan drive override. Assumes the serial port decodes
// host transfers into single-cycle register read and write strobes, and
// that measurement and limit values come in synchronous to clk.
//
// What this block does
// - Both status registers reset to zero
// - Read clears bit only if cause gone
// - First bit0: 2.5 V limit or timer
// - First bits1-3: core, main, 5 V limits
// - First bits4-6: remote1, local, remote2 temps
// - First bit7 is OR of second register
// - Start bit stays writable after lock
// - Monitoring off forces full fan duty
// - Second bit0 latches 12 V limit
// - Code mode: bit0 on code change
// - Code change bit drives alert request
// - Overtemp bit clears below limit minus hysteresis
// - Fan fail bits, suppressed when drive off
// - Fourth fan bit, suppressed by drive three
// - Shared pin: bit5 writes or reads level
// - Timer mode: bit5 on alarm time over
// - Bits6-7 latch diode open or short
// - High is strictly above, low inclusive
// - Fan slow when count exceeds minimum
`timescale 1ns/1ps
`include "monitor_status_regs.svh"

module monitor_interrupt_status (
  input  wire logic                             clk,
  input  wire logic                             reset,
  input  wire logic [7:0]                       reg_addr,
  input  wire logic                             reg_wr_en,
  input  wire logic                             reg_rd_en,
  input  wire logic [7:0]                       reg_wdata,
  output logic      [7:0]                       reg_rdata,
  input  wire logic [7:0][7:0]                  meas_value,
  input  wire logic [7:0][7:0]                  limit_low,
  input  wire logic [7:0][7:0]                  limit_high,
  input  wire logic [3:0][15:0]                 tach_count,
  input  wire logic [3:0][15:0]                 tach_min,
  input  wire logic [2:0][7:0]                  pwm_duty,
  input  wire logic                             pin22_alarm_mode,
  input  wire monitor_status_pkg::pin14_mode_e  pin14_mode,
  input  wire logic                             alarm_timer_over,
  input  wire logic                             overtemp_over,
  input  wire logic                             overtemp_below_hyst,
  input  wire logic [1:0]                       diode_fault,
  input  wire logic                             code_mode,
  input  wire logic [5:0]                       cpu_voltage_code,
  input  wire logic                             shared_general_pin_in,
  output logic                                  shared_general_pin_out,
  output logic                                  shared_general_pin_oe,
  output logic [2:0][7:0]                       fan_drive_duty,
  output logic                                  monitor_start_bit,
  output logic                                  code_alert_req
);

  monitor_status_pkg::status_state_s s_r;
  monitor_status_pkg::status_state_s s_nxt;

  logic [7:0] lim_hit;
  logic [3:0] fan_slow;
  logic [2:0] drive_on;
  logic       code_change;
  logic       running;
  logic       gpio_mode;
  logic       rd_first;
  logic       rd_second;
  logic       wr_cfg;
  logic       wr_second;
  logic [6:0] ev1;
  logic [7:0] ev2;
  logic [7:0] hold2;
  logic [6:0] clr1;
  logic [7:0] clr2;
  logic [7:0] first_view;

  ////////////////////////////////////////////////////////////////////////////
  // High limit strict, low limit inclusive; temperatures are two's complement
  function automatic logic limit_hit(input logic [7:0] v,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi,
                                     input logic       sgn);
    logic hi_x;
    logic lo_x;
    if (sgn) begin
      hi_x = $signed(v) > $signed(hi);
      lo_x = $signed(v) <= $signed(lo);
    end else begin
      hi_x = v > hi;
      lo_x = v <= lo;
    end
    return hi_x | lo_x;
  endfunction : limit_hit

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lim
      assign lim_hit[gi] = limit_hit(meas_value[gi], limit_low[gi], limit_high[gi],
                                     gi >= `MIS_FIRST_TEMP_CH);
    end
    for (gi = 0; gi < 4; gi++) begin : g_fan
      assign fan_slow[gi] = tach_count[gi] > tach_min[gi];
    end
    for (gi = 0; gi < 3; gi++) begin : g_drv
      assign drive_on[gi] = s_r.duty_r[gi] != `MIS_DUTY_OFF;
    end
  endgenerate

  voltage_code_watch u_code_watch (
    .clk          (clk),
    .reset        (reset),
    .code_in      (cpu_voltage_code),
    .code_changed (code_change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event sources, gated by the monitoring start bit
  assign running   = s_r.cfg_r[`MIS_CFG_START];
  assign gpio_mode = (pin14_mode == monitor_status_pkg::PIN14_GPIO_OUT) ||
                     (pin14_mode == monitor_status_pkg::PIN14_GPIO_IN);
  assign rd_first  = reg_rd_en && (reg_addr == `MIS_ADDR_STATUS1);
  assign rd_second = reg_rd_en && (reg_addr == `MIS_ADDR_STATUS2);
  assign wr_cfg    = reg_wr_en && (reg_addr == `MIS_ADDR_CFG1);
  assign wr_second = reg_wr_en && (reg_addr == `MIS_ADDR_STATUS2);

  always_comb begin
    ev1[0] = pin22_alarm_mode ? alarm_timer_over : lim_hit[0];
    ev1[3:1] = lim_hit[3:1];
    ev1[6:4] = lim_hit[7:5];
    ev2[0] = code_mode ? code_change : lim_hit[4];
    ev2[1] = overtemp_over;
    ev2[4:2] = fan_slow[2:0] & drive_on;
    case (pin14_mode)
      monitor_status_pkg::PIN14_TACH:  ev2[5] = fan_slow[3] & drive_on[2];
      monitor_status_pkg::PIN14_TIMER: ev2[5] = alarm_timer_over;
      default:                         ev2[5] = 1'b0;
    endcase
    ev2[7:6] = diode_fault;
    ev1 = running ? ev1 : 7'h00;
    ev2 = running ? ev2 : 8'h00;
    hold2 = ev2;
    hold2[`MIS_S2_OVT] = running & ~overtemp_below_hyst;
  end

  // Clear mask taken from the same state the read returns, so an event in
  // the read cycle survives: set is ORed in after the clear
  assign clr1 = rd_first ? (s_r.first_r & ~ev1) : 7'h00;
  assign clr2 = rd_second ? (s_r.second_r & ~hold2 & ~{2'b00, gpio_mode, 5'h00})
                          : 8'h00;
  assign first_view = {|s_r.second_r, s_r.first_r};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    for (int k = 0; k < 3; k++) begin
      s_nxt.duty_r[k] = running ? pwm_duty[k] : `MIS_FULL_DUTY;
    end
    s_nxt.first_r  = (s_r.first_r & ~clr1) | ev1;
    s_nxt.second_r = (s_r.second_r & ~clr2) | ev2;
    if (pin14_mode == monitor_status_pkg::PIN14_GPIO_OUT) begin
      if (wr_second) begin
        s_nxt.second_r[`MIS_S2_F4P] = reg_wdata[`MIS_S2_F4P];
      end
    end else if (pin14_mode == monitor_status_pkg::PIN14_GPIO_IN) begin
      s_nxt.second_r[`MIS_S2_F4P] = shared_general_pin_in;
    end
    if (wr_cfg) begin
      s_nxt.cfg_r[`MIS_CFG_START]  = reg_wdata[`MIS_CFG_START];
      s_nxt.cfg_r[`MIS_CFG_FSPD]   = reg_wdata[`MIS_CFG_FSPD];
      s_nxt.cfg_r[`MIS_CFG_FSPDIS] = reg_wdata[`MIS_CFG_FSPDIS];
      if (reg_wdata[`MIS_CFG_LOCK]) begin
        s_nxt.cfg_r[`MIS_CFG_LOCK] = 1'b1;
      end
      if (!s_r.cfg_r[`MIS_CFG_LOCK]) begin
        s_nxt.cfg_r[`MIS_CFG_VX1]   = reg_wdata[`MIS_CFG_VX1];
        s_nxt.cfg_r[`MIS_CFG_TODIS] = reg_wdata[`MIS_CFG_TODIS];
      end
    end
    if (reg_rd_en) begin
      if (reg_addr == `MIS_ADDR_CFG1) begin
        s_nxt.rdata_r = s_r.cfg_r;
      end else if (reg_addr == `MIS_ADDR_STATUS1) begin
        s_nxt.rdata_r = first_view;
      end else if (reg_addr == `MIS_ADDR_STATUS2) begin
        s_nxt.rdata_r = s_r.second_r;
      end else begin
        s_nxt.rdata_r = 8'h00;
      end
    end
    if (reset) begin
      s_nxt          = '0;
      s_nxt.cfg_r    = `MIS_CFG1_RESET;
      s_nxt.duty_r   = {3{`MIS_FULL_DUTY}};
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata              = s_r.rdata_r;
  assign fan_drive_duty         = s_r.duty_r;
  assign monitor_start_bit      = s_r.cfg_r[`MIS_CFG_START];
  assign shared_general_pin_out = s_r.second_r[`MIS_S2_F4P];
  assign shared_general_pin_oe  = (pin14_mode == monitor_status_pkg::PIN14_GPIO_OUT);
  // Alert masking lives outside; this only offers the latched code change
  assign code_alert_req         = code_mode & s_r.second_r[`MIS_S2_CODE];

  ////////////////////////////////////////////////////////////////////////////
  reset_zero_a: assert property (
    @(posedge clk) disable iff (reset)
    $past(reset) |-> (s_r.first_r == 7'h00 && s_r.second_r == 8'h00)
  ) else $error("status not zero after reset");

  clear_gone_a: assert property (
    @(posedge clk) disable iff (reset)
    rd_first |=> ((s_r.first_r & $past(s_r.first_r) & ~$past(ev1)) == 7'h00)
  ) else $error("status bit not cleared on read");

  sticky_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    !rd_first |=> ((s_r.first_r & $past(s_r.first_r)) == $past(s_r.first_r))
  ) else $error("status bit lost without read");

  ool_summary_a: assert property (
    @(posedge clk) disable iff (reset)
    rd_first |=> (reg_rdata[`MIS_S1_OOL] == |$past(s_r.second_r))
  ) else $error("summary bit differs from second register");

  start_after_lock_a: assert property (
    @(posedge clk) disable iff (reset)
    (wr_cfg && s_r.cfg_r[`MIS_CFG_LOCK]) |=>
      (monitor_start_bit == $past(reg_wdata[`MIS_CFG_START]))
  ) else $error("start bit not written while locked");

  full_duty_a: assert property (
    @(posedge clk) disable iff (reset)
    !running |=> (fan_drive_duty == {3{`MIS_FULL_DUTY}})
  ) else $error("fan drive not full while stopped");

  fan_off_a: assert property (
    @(posedge clk) disable iff (reset)
    (s_r.duty_r[0] == `MIS_DUTY_OFF && !s_r.second_r[`MIS_S2_FAN_ONE_FAIL_FLAG])
      |=> !s_r.second_r[`MIS_S2_FAN_ONE_FAIL_FLAG]
  ) else $error("fan fail set with drive off");

  timer_bit_a: assert property (
    @(posedge clk) disable iff (reset)
    (pin14_mode == monitor_status_pkg::PIN14_TIMER && running && alarm_timer_over)
      |=> s_r.second_r[`MIS_S2_F4P]
  ) else $error("timer bit not latched");

  gpio_write_a: assert property (
    @(posedge clk) disable iff (reset)
    (pin14_mode == monitor_status_pkg::PIN14_GPIO_OUT && wr_second) ##1
      (pin14_mode == monitor_status_pkg::PIN14_GPIO_OUT)
      |-> (shared_general_pin_out == $past(reg_wdata[`MIS_S2_F4P]) && shared_general_pin_oe)
  ) else $error("shared pin level not written");

  overtemp_keep_a: assert property (
    @(posedge clk) disable iff (reset)
    (rd_second && running && s_r.second_r[`MIS_S2_OVT] && !overtemp_below_hyst)
      |=> s_r.second_r[`MIS_S2_OVT]
  ) else $error("overtemp bit cleared above hysteresis");

  diode_latch_a: assert property (
    @(posedge clk) disable iff (reset)
    (running && diode_fault[0]) |=> s_r.second_r[`MIS_S2_D1] [*1] ##1 1'b1
  ) else $error("diode fault not latched");

endmodule : monitor_interrupt_status

// ==== logic/monitor_status_pkg.sv ====
// Types shared by the monitor status block and its code watcher.
// Assumes the constants header supplies all numeric values.
package monitor_status_pkg;

  typedef enum logic [1:0] {
    PIN14_TACH,
    PIN14_GPIO_OUT,
    PIN14_GPIO_IN,
    PIN14_TIMER
  } pin14_mode_e;

  typedef struct packed {
    logic [6:0]      first_r;
    logic [7:0]      second_r;
    logic [7:0]      cfg_r;
    logic [2:0][7:0] duty_r;
    logic [7:0]      rdata_r;
  } status_state_s;

  typedef struct packed {
    logic [8:0] tick_r;
    logic [5:0] sample_r;
    logic       primed_r;
    logic       change_r;
  } code_watch_s;

endpackage : monitor_status_pkg

// ==== logic/monitor_status_regs.svh ====
// Register offsets, field positions, reset values and timing counts
// for the monitor status block. Definitions only; included by bare name.
`ifndef MONITOR_STATUS_REGS_SVH
`define MONITOR_STATUS_REGS_SVH

`define MIS_ADDR_CFG1       8'h40
`define MIS_ADDR_STATUS1    8'h41
`define MIS_ADDR_STATUS2    8'h42

`define MIS_CFG1_RESET      8'h04
`define MIS_STATUS_RESET    8'h00
`define MIS_FULL_DUTY       8'hff
`define MIS_DUTY_OFF        8'h00

`define MIS_CFG_START       0
`define MIS_CFG_LOCK        1
`define MIS_CFG_FSPD        3
`define MIS_CFG_VX1         4
`define MIS_CFG_FSPDIS      5
`define MIS_CFG_TODIS       6

`define MIS_S1_OOL          7
`define MIS_S2_CODE         0
`define MIS_S2_OVT          1
`define MIS_S2_FAN_ONE_FAIL_FLAG         2
`define MIS_S2_F4P          5
`define MIS_S2_D1           6

`define MIS_FIRST_TEMP_CH   5

`define MIS_CLK_NS          40
`define VC_WATCH_NS         11000
`define VC_WATCH_CYCLES     (`VC_WATCH_NS / `MIS_CLK_NS)

`endif

// ==== logic/voltage_code_watch.sv ====
// Voltage-code change detector: compares the code pins with their value
// one sample period earlier. Code pins are synchronous to clk.
`timescale 1ns/1ps
`include "monitor_status_regs.svh"

module voltage_code_watch (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [5:0] code_in,
  output logic            code_changed
);

  monitor_status_pkg::code_watch_s s_r;
  monitor_status_pkg::code_watch_s s_nxt;
  logic                            tick_last;

  assign tick_last = (s_r.tick_r == 9'(`VC_WATCH_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt          = s_r;
    s_nxt.change_r = 1'b0;
    if (!s_r.primed_r) begin
      // First sample after reset only primes, so no false change
      s_nxt.sample_r = code_in;
      s_nxt.primed_r = 1'b1;
      s_nxt.tick_r   = 9'h000;
    end else if (tick_last) begin
      s_nxt.change_r = (code_in != s_r.sample_r);
      s_nxt.sample_r = code_in;
      s_nxt.tick_r   = 9'h000;
    end else begin
      s_nxt.tick_r = s_r.tick_r + 9'h001;
    end
    if (reset) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign code_changed = s_r.change_r;

  ////////////////////////////////////////////////////////////////////////////
  code_change_pulse_a: assert property (
    @(posedge clk) disable iff (reset)
    (s_r.primed_r && tick_last && code_in != s_r.sample_r) |=> code_changed
  ) else $error("code change not flagged");

  code_period_a: assert property (
    @(posedge clk) disable iff (reset)
    (s_r.primed_r && !tick_last) |=> !code_changed
  ) else $error("code change flagged off the sample tick");

endmodule : voltage_code_watch

// ==== tb/strobe_host.sv ====
// Host side of the register strobes: one read or write per call.
// Assumes the bench clock; drives only on falling edges.
`timescale 1ns/1ps

module strobe_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////
  // Idle bus shows inverted values, never stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    d         = reg_rdata;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
  endtask : rd
endmodule : strobe_host

// ==== tb/testbench.sv ====
// Self-checking bench for the monitor status block.
// Assumes the strobe host model and the constants header.
`timescale 1ns/1ps
`include "monitor_status_regs.svh"

module testbench;
  logic                            clk, reset, reg_wr_en, reg_rd_en;
  logic [7:0]                      reg_addr, reg_wdata, reg_rdata, v, a, e;
  logic [7:0][7:0]                 meas_value, limit_low, limit_high;
  logic [3:0][15:0]                tach_count, tach_min;
  logic [2:0][7:0]                 pwm_duty, fan_drive_duty;
  logic                            pin22_alarm_mode, alarm_timer_over, overtemp_over;
  logic                            overtemp_below_hyst, code_mode, monitor_start_bit;
  logic                            shared_general_pin_in, shared_general_pin_out;
  logic                            shared_general_pin_oe, code_alert_req;
  monitor_status_pkg::pin14_mode_e pin14_mode;
  logic [1:0]                      diode_fault;
  logic [5:0]                      cpu_voltage_code;
  logic [3:0]                      l;
  int                              err_count, checks_done, seed, n;

  monitor_interrupt_status DUT (.clk, .reset, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
    .reg_rdata, .meas_value, .limit_low, .limit_high, .tach_count, .tach_min, .pwm_duty,
    .pin22_alarm_mode, .pin14_mode, .alarm_timer_over, .overtemp_over, .overtemp_below_hyst,
    .diode_fault, .code_mode, .cpu_voltage_code, .shared_general_pin_in,
    .shared_general_pin_out, .shared_general_pin_oe, .fan_drive_duty, .monitor_start_bit,
    .code_alert_req);
  strobe_host HOST (.clk, .reg_rdata, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic x);
    chk8({7'h00, g}, {7'h00, x});
  endtask : chk1

  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask : idle

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // Status place of cause i as {second register, bit}
  function automatic logic [3:0] loc(input int i);
    if (i == 4) return 4'h8;
    if (i == 8) return 4'h9;
    if (i == 15) return 4'h0;
    if (i == 16) return 4'hd;
    if (i < 4) return 4'(i);
    if (i < 8) return 4'(i - 1);
    return 4'(i + 1);
  endfunction : loc

  // Mode 0 clears cause i, 1 raises it, 2 a near miss, 3 the drive-off near miss
  task automatic apply(input int i, input int m);
    logic [31:0] r;
    int          f;
    logic        off;
    r = $random(seed);
    f = (i == 12) ? 3 : i - 9;
    off = (m == 3);
    if (i < 8) begin
      if (m >= 2) limit_high[i] = 8'h50 + {4'h0, r[3:0]};
      meas_value[i] = (m == 0) ? 8'h40 : (m >= 2) ? limit_high[i] :
                      r[4] ? limit_high[i] + 8'h01 : limit_low[i];
    end else if (i == 8) begin
      overtemp_over = (m == 1);
      overtemp_below_hyst = (m == 0);
    end else if (i < 13) begin
      pwm_duty[(f == 3) ? 2 : f] = off ? 8'h00 : 8'h80 | r[15:8];
      // Drive is registered: let it go off before the fan slows
      if (off) @(negedge clk);
      tach_count[f] = (m == 0) ? 16'h0100 : tach_min[f] + {15'h0, m != 2};
    end else if (i < 15) begin
      diode_fault[i - 13] = (m == 1);
    end else if (i == 15) begin
      pin22_alarm_mode = (m == 1);
      alarm_timer_over = (m != 0);
    end else begin
      pin14_mode = (m == 1) ? monitor_status_pkg::PIN14_TIMER : monitor_status_pkg::PIN14_TACH;
      alarm_timer_over = (m != 0);
    end
  endtask : apply

  ////////////////////////////////////////
  initial begin
    seed = 18661;
    reset = 1'b1;
    for (int i = 0; i < 8; i++) begin
      meas_value[i] = 8'h40;
      limit_low[i] = 8'h10;
      limit_high[i] = 8'h70;
    end
    for (int i = 0; i < 4; i++) begin
      tach_count[i] = 16'h0100;
      tach_min[i] = 16'h0200 + 16'($random(seed) & 255);
    end
    pwm_duty = {3{8'h90}};
    pin22_alarm_mode = 1'b0;
    pin14_mode = monitor_status_pkg::PIN14_TACH;
    alarm_timer_over = 1'b0;
    overtemp_over = 1'b0;
    overtemp_below_hyst = 1'b1;
    diode_fault = 2'b00;
    code_mode = 1'b0;
    cpu_voltage_code = 6'h15;
    shared_general_pin_in = 1'b0;
    idle(6);
    reset = 1'b0;
    HOST.rd(`MIS_ADDR_STATUS1, v);
    chk8(v, `MIS_STATUS_RESET);
    HOST.rd(`MIS_ADDR_STATUS2, v);
    chk8(v, `MIS_STATUS_RESET);
    chk8(fan_drive_duty[0], `MIS_FULL_DUTY);
    $display("test reset done");
    HOST.wr(`MIS_ADDR_CFG1, 8'h03);
    idle(1);
    chk8(fan_drive_duty[1], pwm_duty[1]);
    HOST.wr(`MIS_ADDR_CFG1, 8'h02);
    chk1(monitor_start_bit, 1'b0);
    idle(1);
    chk8(fan_drive_duty[2], `MIS_FULL_DUTY);
    HOST.wr(`MIS_ADDR_CFG1, 8'h01);
    chk1(monitor_start_bit, 1'b1);
    $display("test config done");
    // Second pass takes the drive-off near miss for the fans
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 17; i++) begin
        l = loc(i);
        a = l[3] ? `MIS_ADDR_STATUS2 : `MIS_ADDR_STATUS1;
        e = 8'h01 << l[2:0];
        apply(i, 2 + p);
        idle(3);
        HOST.rd(a, v);
        chk8(v, 8'h00);
        apply(i, 1);
        idle(3);
        HOST.rd(a, v);
        chk8(v, e);
        HOST.rd(a, v);
        chk8(v, e);
        if (l[3]) begin
          HOST.rd(`MIS_ADDR_STATUS1, v);
          chk8(v, 8'h80);
        end
        apply(i, 0);
        idle(1);
        HOST.rd(a, v);
        chk8(v, e);
        HOST.rd(a, v);
        chk8(v, 8'h00);
      end
    end
    $display("test events done");
    code_mode = 1'b1;
    cpu_voltage_code = cpu_voltage_code ^ 6'(1 + ($unsigned($random(seed)) % 63));
    for (n = 0; n < 700 && code_alert_req !== 1'b1; n++) idle(1);
    chk1(code_alert_req, 1'b1);
    if (code_alert_req !== 1'b1) print_verdict();
    HOST.rd(`MIS_ADDR_STATUS2, v);
    chk8(v, 8'h01);
    HOST.rd(`MIS_ADDR_STATUS2, v);
    chk8(v, 8'h00);
    code_mode = 1'b0;
    $display("test code done");
    pin14_mode = monitor_status_pkg::PIN14_GPIO_OUT;
    HOST.wr(`MIS_ADDR_STATUS2, 8'h20);
    chk1(shared_general_pin_oe, 1'b1);
    chk1(shared_general_pin_out, 1'b1);
    HOST.rd(`MIS_ADDR_STATUS1, v);
    chk8(v, 8'h80);
    HOST.wr(`MIS_ADDR_STATUS2, 8'h00);
    chk1(shared_general_pin_out, 1'b0);
    pin14_mode = monitor_status_pkg::PIN14_GPIO_IN;
    shared_general_pin_in = 1'b1;
    idle(2);
    chk1(shared_general_pin_oe, 1'b0);
    HOST.rd(`MIS_ADDR_STATUS2, v);
    chk8(v, 8'h20);
    shared_general_pin_in = 1'b0;
    idle(2);
    HOST.rd(`MIS_ADDR_STATUS2, v);
    chk8(v, 8'h00);
    $display("test shared pin done");
    print_verdict();
  end
endmodule : testbench
